/* logic/erad_pkg.sv */
// Package: constants and types for the exception return-address adjust block
// Notes on behaviour
// - Critical input: save address of the instruction that would execute next.
// - Machine check: best-effort save of executing or about-to-execute address.
// - Data storage, alignment, data miss: save faulting load/store address.
// - Instruction storage, program, FP unavailable, instr miss: save faulting address.
// - Debug: save faulting or next address depending on the debug event.
// - Vector/float unavailable and float data: save faulting instruction address.
// - Advance by 4 for long or fixed-32 instructions, by 2 for short ones.
// - ISA status bit is 0 for fixed-32, 1 for variable; short sits high.
// - Page-mode attribute bit: 0 fixed-32 encoding, 1 variable-length encoding.
// - ISA status bit lives in debug control, hidden from ordinary code.
// - Top opcode nibble 0xx1 or 1111 means 32-bit; 0xx0, other 1xxx 16-bit.
// - Halfword masked by 0x9000 equal to 0x1000 starts a 32-bit instruction.
package erad_pkg;
   localparam int ADDR_W = 32;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;
   localparam logic [15:0] LEN_MASK = 16'h9000;
   localparam logic [15:0] LEN_MATCH = 16'h1000;
   localparam logic [3:0] NIB_RSVD = 4'hf;
   localparam logic [2:0] STEP_LONG = 3'h4;
   localparam logic [2:0] STEP_SHORT = 3'h2;
   localparam logic ISA_FIXED = 1'b0;
   localparam logic ISA_VAR = 1'b1;
   // Vector offset numbers
   typedef enum logic [5:0] {
      VEC_CRIT = 6'h00,
      VEC_MCHK = 6'h01,
      VEC_DSTOR = 6'h02,
      VEC_ISTOR = 6'h03,
      VEC_ALIGN = 6'h05,
      VEC_PROG = 6'h06,
      VEC_FPUN = 6'h07,
      VEC_DMISS = 6'h0d,
      VEC_IMISS = 6'h0e,
      VEC_DEBUG = 6'h0f,
      VEC_VFUN = 6'h20,
      VEC_VFDATA = 6'h21
   } erad_vec_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAVED = 2'b01
   } erad_state_type;
endpackage : erad_pkg

/* logic/erad_len_decode.sv */
// Instruction length decode from the first fetched halfword
`timescale 1ns/10ps
module erad_len_decode (
   input wire logic [15:0] halfword,
   input wire logic isa_mode,
   output logic is_long
);
   logic nib_long;
   always_comb begin
      // Mask form; the reserved 1111 nibble is folded in as 32-bit too
      nib_long = ((halfword & erad_pkg::LEN_MASK) == erad_pkg::LEN_MATCH)
         || (halfword[15:12] == erad_pkg::NIB_RSVD);
      // Fixed-32 mode is always long
      is_long = (isa_mode == erad_pkg::ISA_FIXED) || nib_long;
   end
endmodule : erad_len_decode

/* logic/erad_top.sv */
// Exception return-address capture and adjust logic
`timescale 1ns/10ps
module erad_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic exc_valid,
   input wire logic [5:0] exc_vector,
   input wire logic [31:0] fault_addr,
   input wire logic [31:0] next_addr,
   input wire logic debug_use_next,
   input wire logic [15:0] fetch_halfword,
   input wire logic ir_is_var,
   input wire logic page_mode_attr,
   input wire logic use_page_mode,
   input wire logic debug_access,
   input wire logic adjust_req,
   output logic [31:0] save_restore_addr,
   output logic [31:0] machine_check_save_addr,
   output logic [31:0] adjusted_addr,
   output logic adjusted_valid,
   output logic adjusted_long,
   output logic instr_isa_status_bit,
   output logic save_valid
);
   logic [31:0] srr_q, srr_d, mc_q, mc_d, adj_q, adj_d;
   logic adjv_q, adjv_d, long_q, long_d, isa_q, isa_d, sv_q, sv_d;
   logic [31:0] cap_addr;
   logic cap_mc, cap_hit;
   logic isa_mode, is_long;
   logic [15:0] ir_q, ir_d;
   erad_pkg::erad_state_type st_q, st_d;

   // Add path and step constants assume a 32-bit address
   if (erad_pkg::ADDR_W != 32) begin : g_width_chk
      $error("address width must be 32");
   end

   // Mode source: page attribute bit or holding-register status bit
   always_comb begin
      isa_mode = use_page_mode ? page_mode_attr : ir_is_var;
   end

   erad_len_decode u_dec (
      .halfword(ir_q),
      .isa_mode(isa_mode),
      .is_long(is_long)
   );

   // Capture selection per vector
   always_comb begin
      cap_addr = fault_addr;
      cap_mc = 1'b0;
      cap_hit = 1'b1;
      case (exc_vector)
         erad_pkg::VEC_CRIT: cap_addr = next_addr;
         erad_pkg::VEC_MCHK: begin
            cap_addr = fault_addr;
            cap_mc = 1'b1;
         end
         erad_pkg::VEC_DSTOR, erad_pkg::VEC_ALIGN,
         erad_pkg::VEC_DMISS: cap_addr = fault_addr;
         erad_pkg::VEC_ISTOR, erad_pkg::VEC_PROG, erad_pkg::VEC_FPUN,
         erad_pkg::VEC_IMISS: cap_addr = fault_addr;
         erad_pkg::VEC_DEBUG: begin
            cap_addr = debug_use_next ? next_addr : fault_addr;
         end
         erad_pkg::VEC_VFUN,
         erad_pkg::VEC_VFDATA: cap_addr = fault_addr;
         default: cap_hit = 1'b0;
      endcase
   end

   // Next-state for saved addresses, holding register and adjust result
   always_comb begin
      srr_d = srr_q;
      mc_d = mc_q;
      ir_d = ir_q;
      sv_d = sv_q;
      st_d = st_q;
      adj_d = adj_q;
      adjv_d = 1'b0;
      long_d = long_q;
      isa_d = isa_q;
      // Status bit only visible on debug access, otherwise reads zero
      isa_d = debug_access ? ir_is_var : 1'b0;
      case (st_q)
         erad_pkg::ST_IDLE, erad_pkg::ST_SAVED: begin
            if (exc_valid && cap_hit) begin
               if (cap_mc) begin
                  mc_d = cap_addr;
               end else begin
                  srr_d = cap_addr;
               end
               // Short instructions sit in the upper half of the word
               ir_d = fetch_halfword;
               sv_d = 1'b1;
               st_d = erad_pkg::ST_SAVED;
            end else if (adjust_req && st_q == erad_pkg::ST_SAVED) begin
               // Registered one edge after the request
               // Base is always the ordinary save register
               adj_d = srr_q
                  + {29'h0, is_long ? erad_pkg::STEP_LONG
                                    : erad_pkg::STEP_SHORT};
               adjv_d = 1'b1;
               long_d = is_long;
            end
         end
         default: st_d = erad_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         srr_q <= erad_pkg::ADDR_RST;
         mc_q <= erad_pkg::ADDR_RST;
         adj_q <= erad_pkg::ADDR_RST;
         ir_q <= 16'h0000;
         adjv_q <= 1'b0;
         long_q <= 1'b0;
         isa_q <= 1'b0;
         sv_q <= 1'b0;
         st_q <= erad_pkg::ST_IDLE;
      end else begin
         srr_q <= srr_d;
         mc_q <= mc_d;
         adj_q <= adj_d;
         ir_q <= ir_d;
         adjv_q <= adjv_d;
         long_q <= long_d;
         isa_q <= isa_d;
         sv_q <= sv_d;
         st_q <= st_d;
      end
   end

   always_comb begin
      save_restore_addr = srr_q;
      machine_check_save_addr = mc_q;
      adjusted_addr = adj_q;
      adjusted_valid = adjv_q;
      adjusted_long = long_q;
      instr_isa_status_bit = isa_q;
      save_valid = sv_q;
   end

   chk_crit_next_addr: assert property (
      @(posedge clk) disable iff (sys_rst)
      exc_valid && exc_vector == erad_pkg::VEC_CRIT
      |=> save_restore_addr == $past(next_addr))
      else $error("critical save address wrong");
   chk_mchk_addr: assert property (
      @(posedge clk) disable iff (sys_rst)
      exc_valid && exc_vector == erad_pkg::VEC_MCHK
      |=> machine_check_save_addr == $past(fault_addr))
      else $error("machine check save address wrong");
   chk_mchk_srr_keep: assert property (
      @(posedge clk) disable iff (sys_rst)
      exc_valid && exc_vector == erad_pkg::VEC_MCHK
      |=> $stable(save_restore_addr))
      else $error("machine check disturbed the save address");
   chk_mchk_reg_keep: assert property (
      @(posedge clk) disable iff (sys_rst)
      !(exc_valid && exc_vector == erad_pkg::VEC_MCHK)
      |=> $stable(machine_check_save_addr))
      else $error("machine check address moved");
   chk_data_fault: assert property (
      @(posedge clk) disable iff (sys_rst)
      exc_valid && (exc_vector == erad_pkg::VEC_DSTOR
      || exc_vector == erad_pkg::VEC_ALIGN
      || exc_vector == erad_pkg::VEC_DMISS)
      |=> save_restore_addr == $past(fault_addr))
      else $error("data fault save address wrong");
   chk_instr_fault: assert property (
      @(posedge clk) disable iff (sys_rst)
      exc_valid && (exc_vector == erad_pkg::VEC_ISTOR
      || exc_vector == erad_pkg::VEC_PROG || exc_vector == erad_pkg::VEC_IMISS
      || exc_vector == erad_pkg::VEC_FPUN)
      |=> save_restore_addr == $past(fault_addr))
      else $error("instruction fault save address wrong");
   chk_debug_addr: assert property (
      @(posedge clk) disable iff (sys_rst)
      exc_valid && exc_vector == erad_pkg::VEC_DEBUG
      |=> save_restore_addr == ($past(debug_use_next) ? $past(next_addr)
                                : $past(fault_addr)))
      else $error("debug save address wrong");
   chk_vf_fault: assert property (
      @(posedge clk) disable iff (sys_rst)
      exc_valid && (exc_vector == erad_pkg::VEC_VFUN
      || exc_vector == erad_pkg::VEC_VFDATA)
      |=> save_restore_addr == $past(fault_addr))
      else $error("vector float save address wrong");
   chk_save_stands: assert property (
      @(posedge clk) disable iff (sys_rst)
      !exc_valid |=> $stable(save_restore_addr))
      else $error("save address moved without an exception");
   chk_step_size: assert property (
      @(posedge clk) disable iff (sys_rst)
      adjusted_valid |-> adjusted_addr == $past(save_restore_addr)
         + (adjusted_long ? 32'h4 : 32'h2))
      else $error("return step size wrong");
   chk_fixed_long: assert property (
      @(posedge clk) disable iff (sys_rst)
      adjusted_valid && $past(isa_mode) == erad_pkg::ISA_FIXED
      |-> adjusted_long)
      else $error("fixed mode instruction stepped short");
   chk_len_decode: assert property (
      @(posedge clk) disable iff (sys_rst)
      adjusted_valid && $past(isa_mode) == erad_pkg::ISA_VAR
      |-> adjusted_long == (($past(ir_q) & erad_pkg::LEN_MASK)
         == erad_pkg::LEN_MATCH || $past(ir_q[15:12]) == erad_pkg::NIB_RSVD))
      else $error("length decode wrong");
   chk_adj_answer: assert property (
      @(posedge clk) disable iff (sys_rst)
      adjust_req && !exc_valid && save_valid |=> adjusted_valid)
      else $error("adjust request not answered");
   chk_adj_refused: assert property (
      @(posedge clk) disable iff (sys_rst)
      !save_valid |=> !adjusted_valid)
      else $error("adjust answered before any save");
   chk_adj_stands: assert property (
      @(posedge clk) disable iff (sys_rst)
      !adjusted_valid |-> $stable(adjusted_addr))
      else $error("adjusted address moved without a pulse");
   chk_isa_hidden: assert property (
      @(posedge clk) disable iff (sys_rst)
      !debug_access |=> !instr_isa_status_bit)
      else $error("isa status visible without debug access");
   chk_isa_shown: assert property (
      @(posedge clk) disable iff (sys_rst)
      debug_access |=> instr_isa_status_bit == $past(ir_is_var))
      else $error("isa status wrong on debug access");
endmodule : erad_top

/* sim/erad_core_model.sv */
// Pipeline-side model that raises exceptions and adjust requests
`timescale 1ns/10ps
module erad_core_model (
   input wire logic clk,
   output logic exc_valid,
   output logic [5:0] exc_vector,
   output logic [31:0] fault_addr,
   output logic [31:0] next_addr,
   output logic debug_use_next,
   output logic [15:0] fetch_halfword,
   output logic ir_is_var,
   output logic page_mode_attr,
   output logic use_page_mode,
   output logic debug_access,
   output logic adjust_req
);
   initial begin
      {exc_valid, exc_vector, fault_addr, next_addr, debug_use_next} = '0;
      {fetch_halfword, ir_is_var, page_mode_attr, use_page_mode} = '0;
      {debug_access, adjust_req} = '0;
   end
   // Address and halfword lines not qualified by a pulse show inverted data, not the old value
   task automatic exc(input logic [5:0] v, input logic [31:0] fa,
      input logic [31:0] na, input logic dn, input logic [15:0] hw);
      @(posedge clk);
      #1;
      {exc_valid, exc_vector, fault_addr, next_addr} = {1'b1, v, fa, na};
      {debug_use_next, fetch_halfword} = {dn, hw};
      @(posedge clk);
      #1;
      {exc_valid, fault_addr, next_addr, fetch_halfword} = {1'b0, ~fa, ~na, ~hw};
   endtask : exc
   task automatic adj(input logic var_bit, input logic pg, input logic up);
      @(posedge clk);
      #1;
      adjust_req = 1'b1;
      ir_is_var = var_bit;
      {page_mode_attr, use_page_mode} = {pg, up};
      @(posedge clk);
      #1;
      adjust_req = 1'b0;
   endtask : adj
   task automatic dbg(input logic a, input logic v);
      @(posedge clk);
      #1;
      {debug_access, ir_is_var} = {a, v};
   endtask : dbg
endmodule : erad_core_model

/* sim/test_exception_return_address_adjust.sv */
// Self-checking bench for the return-address adjust block
`timescale 1ns/10ps
module test_exception_return_address_adjust;
   logic clk, sys_rst, exc_valid, debug_use_next, ir_is_var, page_mode_attr;
   logic use_page_mode, debug_access, adjust_req, adjusted_valid;
   logic adjusted_long, instr_isa_status_bit, save_valid;
   logic [5:0] exc_vector;
   logic [15:0] fetch_halfword;
   logic [31:0] fault_addr, next_addr, save_restore_addr;
   logic [31:0] machine_check_save_addr, adjusted_addr;
   int error_cnt = 0;
   int checks_done = 0;
   logic [5:0] vecs [13] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h05, 6'h06,
      6'h07, 6'h0d, 6'h0e, 6'h0f, 6'h20, 6'h21, 6'h0f};
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   erad_top dut_u (.clk(clk), .sys_rst(sys_rst), .exc_valid(exc_valid),
      .exc_vector(exc_vector), .fault_addr(fault_addr), .next_addr(next_addr),
      .debug_use_next(debug_use_next), .fetch_halfword(fetch_halfword),
      .ir_is_var(ir_is_var), .page_mode_attr(page_mode_attr),
      .use_page_mode(use_page_mode), .debug_access(debug_access),
      .adjust_req(adjust_req), .save_restore_addr(save_restore_addr),
      .machine_check_save_addr(machine_check_save_addr),
      .adjusted_addr(adjusted_addr), .adjusted_valid(adjusted_valid),
      .adjusted_long(adjusted_long), .save_valid(save_valid),
      .instr_isa_status_bit(instr_isa_status_bit));
   erad_core_model model_u (.clk(clk), .exc_valid(exc_valid),
      .exc_vector(exc_vector), .fault_addr(fault_addr), .next_addr(next_addr),
      .debug_use_next(debug_use_next), .fetch_halfword(fetch_halfword),
      .ir_is_var(ir_is_var), .page_mode_attr(page_mode_attr),
      .use_page_mode(use_page_mode), .debug_access(debug_access),
      .adjust_req(adjust_req));
   task automatic give_verdict();
      if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict
   task automatic cmp_addr(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp_addr
   task automatic cmp_bit(input logic g, input logic e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp_bit
   // An adjust before any save must stay silent
   task automatic t_refused();
      model_u.adj(1'b1, 1'b0, 1'b0);
      cmp_bit(adjusted_valid, 1'b0);
      cmp_bit(save_valid, 1'b0);
   endtask : t_refused
   task automatic t_vectors();
      logic [31:0] fa;
      for (int i = 0; i < 13; i++) begin
         fa = 32'h2000_0000 + 32'(i) * 32'h10;
         model_u.exc(vecs[i], fa, fa + 32'h8, i == 12, 16'h0000);
         if (vecs[i] == 6'h01) cmp_addr(machine_check_save_addr, fa);
         else if (vecs[i] == 6'h00 || i == 12)
            cmp_addr(save_restore_addr, fa + 32'h8);
         else cmp_addr(save_restore_addr, fa);
      end
      model_u.exc(6'h04, 32'hdead_0000, 32'h0, 1'b0, 16'h0000);
      cmp_addr(save_restore_addr, fa + 32'h8);
      cmp_bit(save_valid, 1'b1);
   endtask : t_vectors
   // Nibbles 0..f in variable mode, then fixed and page-selected modes
   task automatic t_length();
      logic [31:0] a;
      logic lng;
      for (int n = 0; n < 19; n++) begin
         a = 32'h0000_4000 + 32'(n) * 32'h100;
         lng = n < 16 ? ((n % 2 == 1 && n < 8) || n == 15) : n != 18;
         model_u.exc(6'h02, a, 32'h0, 1'b0,
            n < 16 ? {4'(n), 12'h0a5} : 16'h00a5);
         model_u.adj(n < 16 || n == 17, n == 18, n > 16);
         cmp_addr(adjusted_addr, a + (lng ? 32'h4 : 32'h2));
         cmp_bit(adjusted_long, lng);
         cmp_bit(adjusted_valid, 1'b1);
         @(posedge clk);
         #1;
         cmp_bit(adjusted_valid, 1'b0);
      end
   endtask : t_length
   // A reset in mid-run clears every output and refuses adjusts again
   task automatic t_reset();
      @(posedge clk);
      #1;
      sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      cmp_addr(save_restore_addr, erad_pkg::ADDR_RST);
      cmp_addr(machine_check_save_addr, erad_pkg::ADDR_RST);
      cmp_addr(adjusted_addr, erad_pkg::ADDR_RST);
      cmp_bit(instr_isa_status_bit, 1'b0);
      t_refused();
   endtask : t_reset
   task automatic t_status();
      for (int k = 0; k < 4; k++) begin
         model_u.dbg(k[1], k[0]);
         @(posedge clk);
         #1;
         cmp_bit(instr_isa_status_bit, k == 3);
      end
   endtask : t_status
   initial begin
      sys_rst = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      t_refused();
      t_vectors();
      t_length();
      t_status();
      t_reset();
      give_verdict();
   end
   // Hang guard
   initial begin
      #100000;
      error_cnt++;
      give_verdict();
   end
endmodule : test_exception_return_address_adjust
